// >>> hdl/ulh_consts.svh
`ifndef ULH_CONSTS_SVH
`define ULH_CONSTS_SVH

// ---------------------------------------------------------------
// clock and handshake times
// ---------------------------------------------------------------
`define ULH_CLK_PERIOD_NS   10
`define ULH_T_KDET_NS       2500
`define ULH_KDET_CYC        ((`ULH_T_KDET_NS + `ULH_CLK_PERIOD_NS - 1) / `ULH_CLK_PERIOD_NS)
`define ULH_T_CHIRP_NS      50000
`define ULH_CHIRP_CYC       (`ULH_T_CHIRP_NS / `ULH_CLK_PERIOD_NS)
`define ULH_T_CHIRP_MIN_NS  40000
`define ULH_T_CHIRP_MAX_NS  60000
`define ULH_T_RESET_NS      10000000
`define ULH_RESET_CYC       (`ULH_T_RESET_NS / `ULH_CLK_PERIOD_NS)
`define ULH_CHIRP_PAIRS     8

// ---------------------------------------------------------------
// link decision windows in clocks
// ---------------------------------------------------------------
`define ULH_TT_HS_CYC       10'h00F
`define ULH_TT_FS_CYC       10'h007
`define ULH_TT_LS_CYC       10'h04D
`define ULH_RT_HS_CYC       10'h001
`define ULH_RESP_HS_CYC     10'h05C
`define ULH_RESP_FS_CYC     10'h050
`define ULH_RESP_LS_CYC     10'h2CE

// ---------------------------------------------------------------
// transceiver commands and values
// ---------------------------------------------------------------
`define ULH_TXCMD_NOPID     8'h40
`define ULH_TXCMD_REGW      8'h80
`define ULH_REG_FUNC        8'h04
`define ULH_FUNC_RESET      8'h50
`define ULH_FUNC_HS         8'h40
`define ULH_FUNC_FS         8'h45
`define ULH_CHIRP_K         8'h00
`define ULH_CHIRP_J         8'hFF
`define ULH_LS_SE0          2'h0
`define ULH_LS_DP_HIGH      2'h1
`define ULH_LS_DM_HIGH      2'h2
`define ULH_LS_K            2'h2

// ---------------------------------------------------------------
// command registers
// ---------------------------------------------------------------
`define ULH_ADDR_CTRL       4'h0
`define ULH_ADDR_STATUS     4'h4
`define ULH_CTRL_START_BIT  0
`define ULH_CTRL_SEND_BIT   1
`define ULH_CTRL_PID_LSB    8
`define ULH_STAT_BUSY_BIT   2
`define ULH_STAT_HS_BIT     3
`define ULH_STAT_TOUT_BIT   4
`define ULH_STAT_LINE_LSB   8
`define ULH_STAT_RXCNT_LSB  16

`endif

// >>> hdl/ulh_pkg.sv
`default_nettype none

package ulh_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_DETECT, ST_REG_CMD, ST_REG_DATA, ST_REG_STP, ST_RESET_WAIT, ST_K_SEEN,
    ST_CHIRP_CMD, ST_CHIRP_TX, ST_CHIRP_STP, ST_READY, ST_PKT_CMD, ST_PKT_STP
  } ulh_state_e;

  typedef enum logic [1:0] {
    ULH_SPD_HS, ULH_SPD_FS, ULH_SPD_LS, ULH_SPD_NONE
  } ulh_speed_e;

  typedef logic [7:0] ulh_byte_t;

endpackage

`default_nettype wire

// >>> hdl/ulh_timer.sv
`default_nettype none

// down counter; done while the count stands at zero
module ulh_timer #(
  parameter int unsigned W = 20
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  input  wire logic         i_load,
  input  wire logic         i_en,
  input  wire logic [W-1:0] i_value,
  output logic              o_done
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (i_load) begin
      cnt_next = i_value;
    end else if (i_en && cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign o_done = (cnt_reg == '0);

endmodule

`default_nettype wire

// >>> hdl/ulh_chirp_host.sv
`include "ulh_consts.svh"
`default_nettype none

// Function
// R1 - DM high: low-speed, skip reset and chirp
// R2 - reset: high-speed select, terminations on, SE0
// R3 - reset also sets chirp operating mode
// R4 - chirp line state read with HS receiver
// R5 - peripheral enters chirp after 2.5 us SE0
// R6 - peripheral Chirp K at least 1 ms
// R7 - sleeping peripheral restarts clock within 5.6 ms
// R8 - no peripheral chirp: hold SE0 to end
// R9 - K for 2.5 us, then chirp within 100 us
// R10 - each host chirp lasts 40 to 60 us
// R11 - peripheral needs K-J-K-J-K-J, 2.5 us each
// R12 - peripheral then enables terminations, normal mode
// R13 - peripheral: squelch means host chirp finished
// R14 - after chirping, host restores normal mode
// R15 - transceiver line-state report delays
// R16 - transceiver transmit start and end delays
// R17 - transceiver receive start and end delays
// R18 - high-speed gaps from transmit/receive events
// R19 - transmit-to-transmit gap per speed
// R20 - full-speed gap starts at SE0-to-J report
// R21 - receive-to-transmit gap per speed
// R22 - high-speed receive end: DIR low or report
// R23 - peripheral accepts receives one clock apart
// R24 - response timeout per speed blocks transmit
// R25 - receive-active low on report or DIR low
// R26 - all counts in interface clock periods
module ulh_chirp_host
  import ulh_pkg::*;
#(
  parameter int unsigned CHIRP_CYC   = `ULH_CHIRP_CYC,
  parameter int unsigned RESET_CYC   = `ULH_RESET_CYC,
  parameter int unsigned CHIRP_PAIRS = `ULH_CHIRP_PAIRS
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_we,
  input  wire logic        i_re,
  output logic      [31:0] o_rdata,
  input  wire logic        i_ulpi_dir,
  input  wire logic        i_ulpi_nxt,
  input  wire logic [7:0]  i_ulpi_data,
  output logic      [7:0]  o_ulpi_data,
  output logic             o_ulpi_data_oe_n,
  output logic             o_ulpi_stp
);

  localparam int unsigned TW = 20;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic rxcmd_act(input ulh_byte_t d);
    return d[4];
  endfunction

  function automatic logic [1:0] j_level(input ulh_speed_e s);
    return (s == ULH_SPD_LS) ? `ULH_LS_DM_HIGH : `ULH_LS_DP_HIGH;
  endfunction

  function automatic ulh_byte_t out_byte(input ulh_state_e st, input ulh_byte_t fv,
                                         input ulh_byte_t cb_val, input logic [3:0] pid);
    unique case (st)
      ST_REG_CMD:   return `ULH_TXCMD_REGW | `ULH_REG_FUNC;
      ST_REG_DATA:  return fv;
      ST_CHIRP_CMD: return `ULH_TXCMD_NOPID;
      ST_CHIRP_TX:  return cb_val;
      ST_PKT_CMD:   return `ULH_TXCMD_NOPID | {4'h0, pid};
      default:      return 8'h00;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // receive tracking
  // ---------------------------------------------------------------
  logic       dir_q_reg;
  logic [1:0] ls_reg;
  logic       rx_act_reg;
  logic [7:0] rx_cnt_reg;
  logic [1:0] ls_next;
  logic       rx_act_next;
  logic [7:0] rx_cnt_next;
  logic       rxcmd_vld;
  logic       rx_start;
  logic       rx_end;
  logic       j_seen;
  ulh_speed_e speed_reg;

  assign rxcmd_vld = i_ulpi_dir & dir_q_reg & ~i_ulpi_nxt;
  assign rx_start  = ~rx_act_reg & ((i_ulpi_dir & ~dir_q_reg & i_ulpi_nxt) | (rxcmd_vld & rxcmd_act(i_ulpi_data)));
  assign rx_end    = rx_act_reg & (~i_ulpi_dir | (rxcmd_vld & ~rxcmd_act(i_ulpi_data))); // [R22] [R25]
  assign j_seen    = rxcmd_vld & (ls_reg == `ULH_LS_SE0) & (i_ulpi_data[1:0] == j_level(speed_reg)); // [R20]

  always_comb begin
    ls_next     = ls_reg;
    rx_act_next = rx_act_reg;
    rx_cnt_next = rx_cnt_reg;
    if (rxcmd_vld) begin
      ls_next = i_ulpi_data[1:0];
    end
    if (rx_end) begin
      rx_act_next = 1'b0;
    end else if (rx_start) begin // [R23]
      rx_act_next = 1'b1;
    end
    if (i_ulpi_dir && dir_q_reg && i_ulpi_nxt) begin
      rx_cnt_next = rx_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      dir_q_reg  <= 1'b1;
      ls_reg     <= `ULH_LS_SE0;
      rx_act_reg <= 1'b0;
      rx_cnt_reg <= 8'h00;
    end else begin
      dir_q_reg  <= i_ulpi_dir;
      ls_reg     <= ls_next;
      rx_act_reg <= rx_act_next;
      rx_cnt_reg <= rx_cnt_next;
    end
  end

  rx_low_a: assert property (rx_act_reg && !i_ulpi_dir |=> !rx_act_reg) // [R25]
    else $error("receive-active stayed high after dir fell");

  // ---------------------------------------------------------------
  // reset and chirp sequencer
  // ---------------------------------------------------------------
  ulh_state_e state_reg;
  ulh_state_e state_next;
  ulh_state_e ret_reg;
  ulh_state_e ret_next;
  ulh_speed_e speed_next;
  ulh_byte_t  func_reg;
  ulh_byte_t  func_next;
  ulh_byte_t  chirp_reg;
  ulh_byte_t  chirp_next;
  logic [7:0] pair_reg;
  logic [7:0] pair_next;
  ulh_byte_t  data_reg;
  logic       stp_reg;
  logic       load_a;
  logic       load_b;
  logic       en_b;
  logic [TW-1:0] val_b;
  logic       tmr_a_done;
  logic       tmr_b_done;
  logic       start_pend_reg;
  logic       pkt_pend_reg;
  logic [3:0] pid_reg;
  logic       gap_ok;
  logic       link_free;

  assign link_free = ~i_ulpi_dir & ~dir_q_reg;
  assign en_b      = (state_reg == ST_RESET_WAIT) ? (ls_reg == `ULH_LS_K) : 1'b1;

  always_comb begin
    state_next = state_reg;
    ret_next   = ret_reg;
    speed_next = speed_reg;
    func_next  = func_reg;
    chirp_next = chirp_reg;
    pair_next  = pair_reg;
    load_a     = 1'b0;
    load_b     = 1'b0;
    val_b      = TW'(`ULH_KDET_CYC);
    unique case (state_reg)
      ST_IDLE: begin
        if (start_pend_reg) state_next = ST_DETECT;
      end
      ST_DETECT: begin
        if (ls_reg == `ULH_LS_DM_HIGH) begin // [R1]
          speed_next = ULH_SPD_LS;
          state_next = ST_READY;
        end else if (ls_reg == `ULH_LS_DP_HIGH) begin // [R2] [R3]
          speed_next = ULH_SPD_FS;
          func_next  = `ULH_FUNC_RESET;
          ret_next   = ST_RESET_WAIT;
          state_next = ST_REG_CMD;
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_REG_CMD: begin
        if (link_free && i_ulpi_nxt) state_next = ST_REG_DATA;
      end
      ST_REG_DATA: begin
        // a turnaround by the transceiver aborts the write; it is retried
        if (i_ulpi_dir) state_next = ST_REG_CMD;
        else if (i_ulpi_nxt) state_next = ST_REG_STP;
      end
      ST_REG_STP: begin
        state_next = ret_reg;
        if (ret_reg == ST_RESET_WAIT) begin
          load_a = 1'b1;
          load_b = 1'b1;
        end
      end
      ST_RESET_WAIT: begin // [R5] [R6]
        if (tmr_a_done) begin // [R8]
          func_next  = `ULH_FUNC_FS;
          ret_next   = ST_READY;
          state_next = ST_REG_CMD;
        end else if (tmr_b_done) begin // [R4] [R9]
          state_next = ST_K_SEEN;
        end else if (ls_reg != `ULH_LS_K) begin
          load_b = 1'b1;
        end
      end
      ST_K_SEEN: begin
        if (tmr_a_done) begin
          func_next  = `ULH_FUNC_FS;
          ret_next   = ST_READY;
          state_next = ST_REG_CMD;
        end else if (ls_reg != `ULH_LS_K) begin // [R9]
          state_next = ST_CHIRP_CMD;
        end
      end
      ST_CHIRP_CMD: begin
        if (link_free && i_ulpi_nxt) begin
          chirp_next = `ULH_CHIRP_K;
          pair_next  = 8'h00;
          val_b      = TW'(CHIRP_CYC);
          load_b     = 1'b1;
          state_next = ST_CHIRP_TX;
        end
      end
      ST_CHIRP_TX: begin
        if (tmr_b_done) begin // [R10]
          if (chirp_reg == `ULH_CHIRP_J && pair_reg == 8'(CHIRP_PAIRS - 1)) begin // [R11]
            state_next = ST_CHIRP_STP;
          end else begin
            chirp_next = ~chirp_reg;
            if (chirp_reg == `ULH_CHIRP_J) pair_next = pair_reg + 8'h01;
            val_b  = TW'(CHIRP_CYC);
            load_b = 1'b1;
          end
        end
      end
      ST_CHIRP_STP: begin // [R12] [R13] [R14]
        speed_next = ULH_SPD_HS;
        func_next  = `ULH_FUNC_HS;
        ret_next   = ST_READY;
        state_next = ST_REG_CMD;
      end
      ST_READY: begin
        if (start_pend_reg) state_next = ST_DETECT;
        else if (pkt_pend_reg && gap_ok && link_free) state_next = ST_PKT_CMD; // [R24]
      end
      ST_PKT_CMD: begin
        if (i_ulpi_dir) state_next = ST_READY;
        else if (i_ulpi_nxt) state_next = ST_PKT_STP;
      end
      ST_PKT_STP: begin
        state_next = ST_READY;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      ret_reg   <= ST_IDLE;
      speed_reg <= ULH_SPD_NONE;
      func_reg  <= 8'h00;
      chirp_reg <= `ULH_CHIRP_K;
      pair_reg  <= 8'h00;
      data_reg  <= 8'h00;
      stp_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      ret_reg   <= ret_next;
      speed_reg <= speed_next;
      func_reg  <= func_next;
      chirp_reg <= chirp_next;
      pair_reg  <= pair_next;
      data_reg  <= out_byte(state_next, func_next, chirp_next, pid_reg);
      stp_reg   <= (state_next == ST_REG_STP) || (state_next == ST_CHIRP_STP) || (state_next == ST_PKT_STP);
    end
  end

  ulh_timer #(.W(TW)) u_reset_tmr (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_load    (load_a),
    .i_en      (1'b1), // [R26]
    .i_value   (TW'(RESET_CYC)), // [R7]
    .o_done    (tmr_a_done)
  );

  ulh_timer #(.W(TW)) u_phase_tmr (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_load    (load_b),
    .i_en      (en_b),
    .i_value   (val_b),
    .o_done    (tmr_b_done)
  );

  assign o_ulpi_data      = data_reg;
  assign o_ulpi_stp       = stp_reg;
  assign o_ulpi_data_oe_n = i_ulpi_dir | dir_q_reg;

  // helper counters for the checks below
  logic [15:0]   k_run_reg;
  logic [TW-1:0] chirp_run_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      k_run_reg     <= 16'h0000;
      chirp_run_reg <= '0;
    end else begin
      k_run_reg     <= (ls_reg == `ULH_LS_K) ? ((k_run_reg == 16'hFFFF) ? k_run_reg : k_run_reg + 16'h0001) : 16'h0000;
      chirp_run_reg <= (state_next != state_reg || chirp_next != chirp_reg) ? '0 : chirp_run_reg + 1'b1;
    end
  end

  ls_skip_a: assert property (state_reg == ST_DETECT && ls_reg == `ULH_LS_DM_HIGH
                              |=> state_reg == ST_READY && speed_reg == ULH_SPD_LS) // [R1]
    else $error("low-speed attach did not skip reset");

  reset_mode_a: assert property (state_reg == ST_REG_DATA && ret_reg == ST_RESET_WAIT
                                 |-> o_ulpi_data[2:0] == 3'h0) // [R2]
    else $error("reset write lacks high-speed select or terminations");

  chirp_opmode_a: assert property (state_reg == ST_REG_DATA && ret_reg == ST_RESET_WAIT
                                   |-> o_ulpi_data[4:3] == 2'h2) // [R3]
    else $error("reset write lacks chirp mode");

  se0_hold_a: assert property (state_reg == ST_RESET_WAIT && !tmr_a_done
                               |=> state_reg == ST_RESET_WAIT || state_reg == ST_K_SEEN) // [R8]
    else $error("reset ended before its time");

  kdet_min_a: assert property ($rose(state_reg == ST_K_SEEN) |-> $past(k_run_reg) >= `ULH_KDET_CYC) // [R9]
    else $error("peripheral K accepted too early");

  chirp_start_a: assert property (state_reg == ST_K_SEEN && ls_reg != `ULH_LS_K && !tmr_a_done
                                   |=> state_reg == ST_CHIRP_CMD ##1 o_ulpi_data == `ULH_TXCMD_NOPID) // [R9]
    else $error("host chirp not started when K ended");

  chirp_len_a: assert property (state_reg == ST_CHIRP_TX && $past(state_reg) == ST_CHIRP_TX && $changed(chirp_reg)
                                |-> $past(chirp_run_reg) == TW'(CHIRP_CYC)) // [R10]
    else $error("chirp length wrong");

  opmode_back_a: assert property (state_reg == ST_REG_DATA && ret_reg == ST_READY && speed_reg == ULH_SPD_HS
                                  |-> o_ulpi_data[4:3] == 2'h0 && o_ulpi_data[1:0] == 2'h0) // [R14]
    else $error("normal mode not restored after chirp");

  // ---------------------------------------------------------------
  // packet gaps and response timeout
  // ---------------------------------------------------------------
  logic [9:0] gap_reg;
  logic [9:0] gap_next;
  logic [9:0] resp_reg;
  logic [9:0] resp_next;
  logic       arm_reg;
  logic       arm_next;
  logic       tout_set;

  assign gap_ok = (gap_reg == 10'h000) && !arm_reg && (resp_reg == 10'h000);

  always_comb begin
    gap_next  = (gap_reg != 10'h000) ? gap_reg - 10'h001 : gap_reg;
    resp_next = (resp_reg != 10'h000) ? resp_reg - 10'h001 : resp_reg;
    arm_next  = arm_reg;
    tout_set  = 1'b0;
    if (state_reg == ST_PKT_STP) begin
      if (speed_reg == ULH_SPD_HS) gap_next = `ULH_TT_HS_CYC; // [R18] [R19]
      else arm_next = 1'b1;
      unique case (speed_reg)
        ULH_SPD_HS: resp_next = `ULH_RESP_HS_CYC; // [R24]
        ULH_SPD_LS: resp_next = `ULH_RESP_LS_CYC;
        default:    resp_next = `ULH_RESP_FS_CYC;
      endcase
    end
    if (rx_start) begin
      resp_next = 10'h000;
    end else if (resp_reg == 10'h001) begin
      tout_set = 1'b1;
    end
    if (rx_end) begin // [R21] [R22]
      if (speed_reg == ULH_SPD_HS) gap_next = `ULH_RT_HS_CYC;
      else arm_next = 1'b1;
    end
    if (arm_reg && j_seen) begin // [R20]
      arm_next = 1'b0;
      gap_next = (speed_reg == ULH_SPD_LS) ? `ULH_TT_LS_CYC : `ULH_TT_FS_CYC;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      gap_reg  <= 10'h000;
      resp_reg <= 10'h000;
      arm_reg  <= 1'b0;
    end else begin
      gap_reg  <= gap_next;
      resp_reg <= resp_next;
      arm_reg  <= arm_next;
    end
  end

  hs_gap_a: assert property (state_reg == ST_PKT_STP && speed_reg == ULH_SPD_HS
                             |=> gap_reg == `ULH_TT_HS_CYC && resp_reg == `ULH_RESP_HS_CYC) // [R19]
    else $error("high-speed gap or timeout not started at stp");

  tx_gate_a: assert property (state_reg == ST_READY ##1 state_reg == ST_PKT_CMD
                              |-> $past(gap_reg) == 10'h000 && $past(resp_reg) == 10'h000 && !$past(arm_reg)) // [R24]
    else $error("transmit started inside gap or timeout");

  // ---------------------------------------------------------------
  // command registers
  // ---------------------------------------------------------------
  logic        start_next;
  logic        pkt_next;
  logic [3:0]  pid_next;
  logic        tout_reg;
  logic        tout_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        wr_ctrl;

  assign wr_ctrl = i_we && (i_addr == `ULH_ADDR_CTRL);

  always_comb begin
    start_next = (state_reg == ST_DETECT) ? 1'b0 : start_pend_reg;
    pkt_next   = (state_reg == ST_PKT_STP) ? 1'b0 : pkt_pend_reg;
    pid_next   = pid_reg;
    tout_next  = tout_reg;
    rdata_next = 32'h0000_0000;
    if (i_we && i_addr == `ULH_ADDR_STATUS && i_wdata[`ULH_STAT_TOUT_BIT]) tout_next = 1'b0;
    if (tout_set) tout_next = 1'b1;
    if (wr_ctrl) begin
      if (i_wdata[`ULH_CTRL_START_BIT]) start_next = 1'b1;
      if (i_wdata[`ULH_CTRL_SEND_BIT]) begin
        pkt_next = 1'b1;
        pid_next = i_wdata[`ULH_CTRL_PID_LSB +: 4];
      end
    end
    if (i_re) begin
      unique case (i_addr)
        `ULH_ADDR_CTRL: begin
          rdata_next[`ULH_CTRL_START_BIT]    = start_pend_reg;
          rdata_next[`ULH_CTRL_SEND_BIT]     = pkt_pend_reg;
          rdata_next[`ULH_CTRL_PID_LSB +: 4] = pid_reg;
        end
        `ULH_ADDR_STATUS: begin
          rdata_next[1:0]                        = speed_reg;
          rdata_next[`ULH_STAT_BUSY_BIT]         = (state_reg != ST_IDLE) && (state_reg != ST_READY);
          rdata_next[`ULH_STAT_HS_BIT]           = (speed_reg == ULH_SPD_HS);
          rdata_next[`ULH_STAT_TOUT_BIT]         = tout_reg;
          rdata_next[`ULH_STAT_LINE_LSB +: 2]    = ls_reg;
          rdata_next[`ULH_STAT_RXCNT_LSB +: 8]   = rx_cnt_reg;
        end
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      start_pend_reg <= 1'b0;
      pkt_pend_reg   <= 1'b0;
      pid_reg        <= 4'h0;
      tout_reg       <= 1'b0;
      rdata_reg      <= 32'h0000_0000;
    end else begin
      start_pend_reg <= start_next;
      pkt_pend_reg   <= pkt_next;
      pid_reg        <= pid_next;
      tout_reg       <= tout_next;
      rdata_reg      <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;

endmodule

`default_nettype wire

// >>> tb/ulh_phy_model.sv
`default_nettype none

// transceiver side: takes tx commands, reports line state by rxcmd
module ulh_phy_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_link_data,
  input  wire logic       i_link_oe_n,
  input  wire logic       i_stp,
  output logic            o_dir,
  output logic            o_nxt,
  output logic [7:0]      o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  initial begin
    o_dir = 1'b0;
    o_nxt = 1'b0;
    o_data = 8'h00;
  end
  // turnaround cycle, one rxcmd byte, then the bus is released
  task automatic report(input logic [1:0] ls);
    repeat (4) @(posedge i_sys_clk);
    while (busy) @(posedge i_sys_clk);
    o_dir <= 1'b1;
    o_data <= ~o_data;
    @(posedge i_sys_clk);
    o_data <= {6'h00, ls};
    @(posedge i_sys_clk);
    o_dir <= 1'b0;
    o_data <= {6'h3F, ~ls};
  endtask
  // receive: dir and nxt rise together, one turnaround, nb bytes, then dir falls
  task automatic rx_pkt(input int nb);
    while (busy) @(posedge i_sys_clk);
    @(posedge i_sys_clk);
    o_dir <= 1'b1;
    o_nxt <= 1'b1;
    repeat (nb + 1) @(posedge i_sys_clk);
    o_dir <= 1'b0;
    o_nxt <= 1'b0;
  endtask
  always @(posedge i_sys_clk) begin
    if (i_rst || i_stp) begin
      busy <= 1'b0;
      o_nxt <= 1'b0;
    end else if (!o_dir && !i_link_oe_n && i_link_data != 8'h00) begin
      busy <= 1'b1;
      o_nxt <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// >>> tb/tb.sv
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CHIRP_CYC = 50;
  localparam int unsigned RESET_CYC = 2000;
  localparam int unsigned PAIRS     = 3;
  logic        i_sys_clk, i_rst, i_we, i_re, dir, nxt, oe_n, stp;
  logic [3:0]  i_addr;
  logic [31:0] i_wdata, rdata, rd_val;
  logic [7:0]  phy_d, link_d, lfsr;
  int          mismatches, cmp_count, n, tx_cnt;

  ulh_chirp_host #(.CHIRP_CYC(CHIRP_CYC), .RESET_CYC(RESET_CYC), .CHIRP_PAIRS(PAIRS)) ulh_chirp_host_inst (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
    .i_re(i_re), .o_rdata(rdata), .i_ulpi_dir(dir), .i_ulpi_nxt(nxt), .i_ulpi_data(phy_d),
    .o_ulpi_data(link_d), .o_ulpi_data_oe_n(oe_n), .o_ulpi_stp(stp));
  ulh_phy_model ulh_phy_model_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_link_data(link_d),
    .i_link_oe_n(oe_n), .i_stp(stp), .o_dir(dir), .o_nxt(nxt), .o_data(phy_d));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_we <= 1'b1;
    @(posedge i_sys_clk);
    i_we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_re <= 1'b1;
    @(posedge i_sys_clk);
    i_re <= 1'b0;
    #1 rd_val = rdata;
  endtask
  task automatic wait_byte(input logic [7:0] v, input int lim);
    n = 0;
    do begin
      @(posedge i_sys_clk);
      #1 n++;
    end while (!(oe_n === 1'b0 && link_d === v) && n < lim);
    `CHK("tx byte", v, link_d)
  endtask
  task automatic do_reset;
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    i_rst <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge i_sys_clk) if (oe_n === 1'b0 && link_d !== 8'h00) tx_cnt++;
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    mismatches++;
    give_verdict;
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    i_rst = 1'b1;
    i_we = 1'b0;
    i_re = 1'b0;
    i_addr = 4'h0;
    i_wdata = 32'h0;
    lfsr = 8'h3E;
    do_reset;
    rd(4'h4);
    `CHK("idle status", 32'h3, rd_val & 32'h31F)
    wr(4'hC, 32'hFFFF_FFFF);
    rd(4'hC);
    `CHK("unmapped", 32'h0, rd_val)
    // low-speed attach
    ulh_phy_model_inst.report(2'h2);
    n = tx_cnt;
    wr(4'h0, 32'h1);
    repeat (30) @(posedge i_sys_clk);
    rd(4'h4);
    `CHK("ls speed", 2'h2, rd_val[1:0])
    `CHK("ls no writes", n, tx_cnt)
    // full-speed attach with chirp handshake
    do_reset;
    ulh_phy_model_inst.report(2'h1);
    wr(4'h0, 32'h1);
    wait_byte(8'h84, 20);
    wait_byte(8'h50, 10);
    lfsr = lfsr_next(lfsr);
    ulh_phy_model_inst.report(2'h2);
    repeat (250 + lfsr[5:0]) @(posedge i_sys_clk);
    ulh_phy_model_inst.report(2'h0);
    wait_byte(8'h40, 10000);
    for (int i = 0; i < 2 * PAIRS; i++) begin
      n = 0;
      while (link_d === 8'h40 && !stp) begin
        @(posedge i_sys_clk);
        #1;
      end
      while (link_d === (i[0] ? 8'hFF : 8'h00) && !stp && n < 1000) begin
        @(posedge i_sys_clk);
        #1 n++;
      end
      `CHK("chirp len", CHIRP_CYC + 1, n)
    end
    `CHK("chirp end", 1'b1, stp)
    wait_byte(8'h84, 20);
    wait_byte(8'h40, 10);
    repeat (5) @(posedge i_sys_clk);
    rd(4'h4);
    `CHK("hs status", 4'h8, rd_val[3:0])
    // token and response timeout
    lfsr = lfsr_next(lfsr);
    wr(4'h0, {20'h0, lfsr[3:0], 8'h02});
    n = 0;
    while (stp !== 1'b1 && n < 100) begin
      @(posedge i_sys_clk);
      #1 n++;
    end
    repeat (87) @(posedge i_sys_clk);
    rd(4'h4);
    `CHK("early timeout", 1'b0, rd_val[4])
    repeat (6) @(posedge i_sys_clk);
    rd(4'h4);
    `CHK("timeout", 1'b1, rd_val[4])
    wr(4'h4, 32'h10);
    rd(4'h4);
    `CHK("timeout clear", 1'b0, rd_val[4])
    // token answered by a packet: no timeout, received bytes counted
    wr(4'h0, {20'h0, lfsr[3:0], 8'h02});
    n = 0;
    while (stp !== 1'b1 && n < 100) begin
      @(posedge i_sys_clk);
      #1 n++;
    end
    n = 1 + lfsr[6:4];
    ulh_phy_model_inst.rx_pkt(n);
    repeat (100) @(posedge i_sys_clk);
    rd(4'h4);
    `CHK("answered", 1'b0, rd_val[4])
    `CHK("rx bytes", n, rd_val[23:16])
    // no peripheral chirp: bus reset runs to the end
    do_reset;
    ulh_phy_model_inst.report(2'h1);
    wr(4'h0, 32'h1);
    wait_byte(8'h50, 20);
    wait_byte(8'h45, RESET_CYC + 100);
    `CHK("se0 held", 1'b1, n >= RESET_CYC)
    give_verdict;
  end
endmodule

`default_nettype wire
